// ---- dv/ecs_far_deser.sv ----
`timescale 1ns/1ps
`default_nettype none
module ecs_far_deser (
	input wire logic mclk_i,
	input wire logic word_clock_i,
	input wire logic [7:0] line_i,
	output logic [7:0][4:0] highs_o,
	output logic [7:0][3:0] rises_o,
	output logic [7:0] lock_n_o
);
	logic wclk_ff = 1'b0;
	logic [2:0] phase_ff = 3'h7;
	logic [7:0] prev_ff = 8'h00;
	logic [7:0][4:0] hcnt_ff = '0;
	logic [7:0][3:0] rcnt_ff = '0;
	logic [7:0] miss_ff = 8'h00;
	initial begin
		highs_o = '0;
		rises_o = '0;
		lock_n_o = 8'hFF;
	end
	// one window per word period, starting just before the start bit
	always @(posedge mclk_i) begin
		wclk_ff <= word_clock_i;
		phase_ff <= (word_clock_i && !wclk_ff) ? 3'h0 : (phase_ff == 3'h7 ? 3'h7 : phase_ff + 3'h1);
		for (int c = 0; c < 8; c++) begin
			logic hi;
			logic ri;
			hi = (line_i[c] === 1'b1);
			ri = hi && !prev_ff[c];
			prev_ff[c] <= hi;
			if (phase_ff == 3'h3) begin
				highs_o[c] <= hcnt_ff[c];
				rises_o[c] <= rcnt_ff[c];
				hcnt_ff[c] <= {4'h0, hi};
				rcnt_ff[c] <= {3'h0, ri};
				// lock lost after two windows without a clock edge
				miss_ff[c] <= (rcnt_ff[c] == 4'h0);
				if (rcnt_ff[c] != 4'h0) begin
					lock_n_o[c] <= 1'b0;
				end else if (miss_ff[c]) begin
					lock_n_o[c] <= 1'b1;
				end
			end else begin
				hcnt_ff[c] <= hcnt_ff[c] + {4'h0, hi};
				rcnt_ff[c] <= rcnt_ff[c] + {3'h0, ri};
			end
		end
	end
endmodule : ecs_far_deser
`default_nettype wire

// ---- dv/ecs_serializer_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ecs_serializer_sva (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic parallel_word_clock_i,
	input wire logic output_drive_enable_i,
	input wire logic global_sleep_n_i,
	input wire logic [ecs_pkg::CHANNELS-1:0] channel_sleep_n_i,
	input wire logic [ecs_pkg::CHANNELS-1:0] serial_out_pair_oe_n_o,
	input wire logic link_ready_o,
	input wire logic [ecs_pkg::CHANNELS-1:0] channel_ready_o
);
	// ------
	// helpers
	// ------
	logic [4:0][ecs_pkg::CHANNELS-1:0] off_ff;
	logic [ecs_pkg::CHANNELS-1:0] held;
	logic [ecs_pkg::CHANNELS-1:0] recent;
	logic [9:0] words_ff;
	logic wclk_ff;
	assign held = off_ff[0] & off_ff[1] & off_ff[2] & off_ff[3] & off_ff[4];
	assign recent = off_ff[0] | off_ff[1] | off_ff[2] | off_ff[3] | off_ff[4];
	always_ff @(posedge mclk_i) begin
		off_ff <= {off_ff[3:0], ~channel_sleep_n_i | {ecs_pkg::CHANNELS{~global_sleep_n_i}}};
	end
	// word edges since leaving sleep, saturating
	always_ff @(posedge mclk_i) begin
		wclk_ff <= parallel_word_clock_i;
		if (reset_i || !global_sleep_n_i) begin
			words_ff <= 10'h000;
		end else if (parallel_word_clock_i && !wclk_ff && words_ff != 10'h3FF) begin
			words_ff <= words_ff + 10'h001;
		end
	end
	// ------
	// checks
	// ------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	drive_off_a: assert property ((!output_drive_enable_i)[*5] |-> &serial_out_pair_oe_n_o)
		else $error("output driven with drive enable low");
	sleep_all_a: assert property ((!global_sleep_n_i)[*5] |-> &serial_out_pair_oe_n_o && !link_ready_o)
		else $error("output or link active in global sleep");
	sleep_chan_a: assert property ((held & ~serial_out_pair_oe_n_o) == '0)
		else $error("sleeping channel drives its output");
	init_wait_a: assert property ((!link_ready_o)[*5] |-> &serial_out_pair_oe_n_o)
		else $error("output driven before lock wait ends");
	ready_order_a: assert property (!link_ready_o |-> channel_ready_o == '0)
		else $error("channel ready without link ready");
	lock_time_a: assert property ($rose(link_ready_o) |-> words_ff inside {[10'h1FD:10'h201]})
		else $error("link ready after wrong number of word clocks");
	wake_time_a: assert property ($rose(channel_ready_o[0]) |-> words_ff inside {[10'h239:10'h23F]})
		else $error("channel ready after wrong number of word clocks");
	ready_keep_a: assert property ((($past(channel_ready_o) & ~channel_ready_o) & ~recent) == '0)
		else $error("channel ready lost without sleep");
	cover property ($rose(link_ready_o));
	cover property ($rose(serial_out_pair_oe_n_o[7]));
	cover property ($fell(output_drive_enable_i) ##5 &serial_out_pair_oe_n_o);
endmodule : ecs_serializer_sva
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic wclk = 1'b0;
	logic [3:0] wcnt = 4'h0;
	logic [ecs_pkg::WORD_BITS-1:0] din = '0;
	logic [7:0] align = 8'h00;
	logic output_drive_enable = 1'b1;
	logic gsn = 1'b1;
	logic [7:0] csn = 8'hFF;
	logic act = 1'b0;
	logic [3:0] sel = 4'hF;
	logic [7:0] p, n, oe_n, cready, lock_n;
	logic accept, lready;
	wire [7:0] line;
	logic [7:0][4:0] highs;
	logic [7:0][3:0] rises;
	int n_errors = 0;
	int n_tests = 0;
	logic [9:0] d_tab [8] = '{10'h000, 10'h3FF, 10'h001, 10'h200, 10'h2AA, 10'h155, 10'h0F0, 10'h30C};
	always #5 mclk_i = ~mclk_i;
	// word clock of 16 system clocks
	always @(posedge mclk_i) begin
		wcnt <= wcnt + 4'h1;
		wclk <= wcnt[3];
	end
	for (genvar c = 0; c < 8; c++) begin : g_line
		assign line[c] = oe_n[c] ? 1'bz : p[c];
	end
	ecs_serializer_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .parallel_word_clock_i(wclk),
		.channel_data_in_i(din), .channel_align_request_i(align), .output_drive_enable_i(output_drive_enable),
		.global_sleep_n_i(gsn), .channel_sleep_n_i(csn), .selftest_activate_i(act),
		.selftest_channel_select_i(sel), .serial_out_pair_p_o(p), .serial_out_pair_n_o(n),
		.serial_out_pair_oe_n_o(oe_n), .word_accept_o(accept), .link_ready_o(lready),
		.channel_ready_o(cready));
	ecs_far_deser far (.mclk_i(mclk_i), .word_clock_i(wclk), .line_i(line), .highs_o(highs),
		.rises_o(rises), .lock_n_o(lock_n));
	// ------
	// tasks
	// ------
	task automatic end_sim;
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic periods(input int k);
		repeat (k) begin
			@(posedge mclk_i);
			while (wcnt !== 4'h0) @(posedge mclk_i);
		end
	endtask : periods
	task automatic wait_ready(input int lim);
		int k;
		k = 0;
		while (cready[0] !== 1'b1 && k < lim) begin
			periods(1);
			k++;
		end
		check("ready", 12'h001, {11'h000, cready[0]});
	endtask : wait_ready
	// frame sent lsb first after a low stop bit
	task automatic check_frame(input int c, input logic [11:0] fr);
		logic prev;
		logic [3:0] r;
		logic [4:0] b;
		logic ok;
		prev = 1'b0;
		r = 4'h0;
		b = 5'h00;
		for (int i = 0; i < 12; i++) begin
			r += {3'h0, fr[i] & ~prev};
			b += {4'h0, fr[i]};
			prev = fr[i];
		end
		ok = (3 * highs[c] + 4 >= 4 * b) && (3 * highs[c] <= 4 * b + 4);
		check($sformatf("rises%0d", c), {8'h00, r}, {8'h00, rises[c]});
		check($sformatf("highs%0d", c), 12'h001, {11'h000, ok});
	endtask : check_frame
	function automatic logic [11:0] fr_of(input logic [9:0] d);
		return {ecs_pkg::STOP_BIT, d, ecs_pkg::START_BIT};
	endfunction : fr_of
	// ------
	// tests
	// ------
	initial begin
		#500000;
		n_errors++;
		end_sim;
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		check("oe_n", 12'h0FF, {4'h0, oe_n});
		check("link_ready", 12'h000, {11'h000, lready});
		for (int c = 0; c < 8; c++) din[10*c +: 10] <= d_tab[c];
		wait_ready(700);
		periods(3);
		for (int c = 0; c < 8; c++) check_frame(c, fr_of(d_tab[c]));
		check("link_ready", 12'h001, {11'h000, lready});
		check("accept", 12'h001, {11'h000, accept});
		check("n", {4'h0, ~p}, {4'h0, n});
		check("lock_n", 12'h000, {4'h0, lock_n});
		align[4] <= 1'b1;
		periods(2);
		check_frame(4, fr_of(d_tab[4]));
		periods(5);
		check_frame(4, ecs_pkg::ALIGN_FRAME);
		check_frame(5, fr_of(d_tab[5]));
		align[4] <= 1'b0;
		periods(3);
		check_frame(4, fr_of(d_tab[4]));
		din <= '0;
		for (int s = 0; s < 17; s++) begin
			logic [7:0] seen;
			logic [7:0] exp;
			act <= (s < 16);
			sel <= (s < 16) ? s[3:0] : 4'h8;
			periods(3);
			seen = 8'h00;
			for (int w = 0; w < 4; w++) begin
				periods(1);
				for (int c = 0; c < 8; c++) if (rises[c] !== 4'h1) seen[c] = 1'b1;
			end
			exp = (s > 8) ? 8'h00 : (s == 8) ? 8'hFF : 8'h01 << s;
			check("selftest", {4'h0, exp}, {4'h0, seen});
		end
		act <= 1'b0;
		for (int c = 0; c < 8; c++) din[10*c +: 10] <= d_tab[c];
		csn[7] <= 1'b0;
		periods(2);
		check("oe_n", 12'h080, {4'h0, oe_n});
		output_drive_enable <= 1'b0;
		periods(2);
		check("oe_n", 12'h0FF, {4'h0, oe_n});
		check("highs0", 12'h000, {7'h00, highs[0]});
		output_drive_enable <= 1'b1;
		periods(3);
		check("oe_n", 12'h080, {4'h0, oe_n});
		check_frame(1, fr_of(d_tab[1]));
		csn[7] <= 1'b1;
		periods(70);
		check("oe_n", 12'h000, {4'h0, oe_n});
		gsn <= 1'b0;
		periods(2);
		check("oe_n", 12'h0FF, {4'h0, oe_n});
		check("link_ready", 12'h000, {11'h000, lready});
		gsn <= 1'b1;
		wait_ready(700);
		periods(3);
		check_frame(0, fr_of(d_tab[0]));
		end_sim;
	end
endmodule : tb
bind ecs_serializer_top ecs_serializer_sva chk (.mclk_i(mclk_i), .reset_i(reset_i),
	.parallel_word_clock_i(parallel_word_clock_i), .output_drive_enable_i(output_drive_enable_i),
	.global_sleep_n_i(global_sleep_n_i), .channel_sleep_n_i(channel_sleep_n_i),
	.serial_out_pair_oe_n_o(serial_out_pair_oe_n_o), .link_ready_o(link_ready_o),
	.channel_ready_o(channel_ready_o));
`default_nettype wire

// ---- src/ecs_lane_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ecs_lane_if;
	logic [ecs_pkg::CHANNELS-1:0][ecs_pkg::FRAME_BITS-1:0] frames;
	logic load;
	logic tick;
	logic [ecs_pkg::CHANNELS-1:0] bits;

	modport ctrl (output frames, output load, output tick, input bits);
	modport lane (input frames, input load, input tick, output bits);
endinterface : ecs_lane_if
`default_nettype wire

// ---- src/ecs_lane_shifter.sv ----
`timescale 1ns/1ps
`default_nettype none
module ecs_lane_shifter (
	input wire logic clk_i,
	input wire logic reset_i,
	ecs_lane_if.lane lane
);
	logic [ecs_pkg::CHANNELS-1:0][ecs_pkg::FRAME_BITS-1:0] shift_ff;

	// load wins over shift; bit 0 (start) is on the line first
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			shift_ff <= '0;
		end else if (lane.load) begin
			shift_ff <= lane.frames;
		end else if (lane.tick) begin
			for (int c = 0; c < ecs_pkg::CHANNELS; c++) begin
				shift_ff[c] <= {1'b0, shift_ff[c][ecs_pkg::FRAME_BITS-1:1]};
			end
		end
	end

	always_comb begin
		for (int c = 0; c < ecs_pkg::CHANNELS; c++) begin
			lane.bits[c] = shift_ff[c][0];
		end
	end
endmodule : ecs_lane_shifter
`default_nettype wire

// ---- src/ecs_pkg.sv ----
package ecs_pkg;
	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int CHANNELS = 8;
	localparam int DATA_BITS = 10;
	localparam int FRAME_BITS = 12;
	localparam int WORD_BITS = CHANNELS * DATA_BITS;
	localparam int FIFO_DEPTH = 16;
	localparam int SEL_BITS = 4;

	// ----------------------------------------------------------------
	// framing
	// ----------------------------------------------------------------
	localparam logic START_BIT = 1'b1;
	localparam logic STOP_BIT = 1'b0;
	// six ones go out first, then six zeros
	localparam logic [FRAME_BITS-1:0] ALIGN_FRAME = 12'h03F;
	localparam logic [3:0] LAST_BIT_IDX = 4'hB;
	localparam logic [3:0] BITS_PER_WORD = 4'hC;

	// ----------------------------------------------------------------
	// timing in word clock periods
	// ----------------------------------------------------------------
	localparam int ALIGN_HOLD_WORDS = 4;
	localparam int PLL_LOCK_WORDS = 510;
	localparam int CHAN_WAKE_WORDS = 60;
	localparam logic [2:0] ALIGN_HOLD = 3'(ALIGN_HOLD_WORDS);
	localparam logic [9:0] PLL_LOCK = 10'(PLL_LOCK_WORDS);
	localparam logic [6:0] CHAN_WAKE = 7'(CHAN_WAKE_WORDS);

	// ----------------------------------------------------------------
	// word clock period measurement, in system clock cycles
	// ----------------------------------------------------------------
	localparam int PERIOD_W = 8;
	localparam logic [PERIOD_W-1:0] PERIOD_DEFAULT = 8'h10;
	localparam logic [PERIOD_W-1:0] PERIOD_MAX = 8'hFF;

	// ----------------------------------------------------------------
	// self-test
	// ----------------------------------------------------------------
	localparam logic [SEL_BITS-1:0] SEL_ALL = 4'h8;
	localparam int PRBS_W = 15;
	localparam logic [PRBS_W-1:0] PRBS_SEED = 15'h7FFF;
endpackage : ecs_pkg

// ---- src/ecs_serializer_top.sv ----
// Notes on behaviour
// - all channels capture their 10-bit word on each shared word clock rise
// - each channel sends its own independent framed serial stream
// - each word framed by start bit one and stop bit zero
// - twelve serial bits go out per word clock period
// - alignment pattern is six ones then six zeros per word
// - request high for 4 word clocks replaces data by alignment patterns
// - request low ends alignment patterns and resumes framed data
// - data sent only with drive enabled, both sleeps high, request low or high under 4 word clocks
// - drive enable low puts all eight outputs at high impedance
// - drive enable back high resumes previous state unchanged
// - after power-on outputs stay off until the PLL lock wait and then the channel wake wait end
// - global sleep low stops PLL and turns every output off
// - leaving global sleep restarts initialization; source waits before data
// - channel sleep low disables only that channel
// - self-test channel sends pseudo-random payload instead of input data
// - select 0 to 7 with activate high tests that one channel
// - select 8 with activate high tests all channels
// - select 9 to 15 performs no self-test
// - activate low means no self-test at all
`timescale 1ns/1ps
`default_nettype none
module ecs_serializer_top (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic parallel_word_clock_i,
	input wire logic [ecs_pkg::WORD_BITS-1:0] channel_data_in_i,
	input wire logic [ecs_pkg::CHANNELS-1:0] channel_align_request_i,
	input wire logic output_drive_enable_i,
	input wire logic global_sleep_n_i,
	input wire logic [ecs_pkg::CHANNELS-1:0] channel_sleep_n_i,
	input wire logic selftest_activate_i,
	input wire logic [ecs_pkg::SEL_BITS-1:0] selftest_channel_select_i,
	output logic [ecs_pkg::CHANNELS-1:0] serial_out_pair_p_o,
	output logic [ecs_pkg::CHANNELS-1:0] serial_out_pair_n_o,
	output logic [ecs_pkg::CHANNELS-1:0] serial_out_pair_oe_n_o,
	output logic word_accept_o,
	output logic link_ready_o,
	output logic [ecs_pkg::CHANNELS-1:0] channel_ready_o
);
	localparam int SYNC_W = 1 + ecs_pkg::WORD_BITS + 2 * ecs_pkg::CHANNELS + 3
		+ ecs_pkg::SEL_BITS;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [ecs_pkg::CHANNELS-1:0] selftest_mask(
		input logic act,
		input logic [ecs_pkg::SEL_BITS-1:0] sel
	);
		logic [ecs_pkg::CHANNELS-1:0] m;
		m = '0;
		if (!act) begin
			m = '0;
		end else if (sel < ecs_pkg::SEL_ALL) begin
			m[sel[2:0]] = 1'b1;
		end else if (sel == ecs_pkg::SEL_ALL) begin
			m = '1;
		end else begin
			m = '0;
		end
		return m;
	endfunction : selftest_mask

	function automatic logic [ecs_pkg::FRAME_BITS-1:0] framed(
		input logic [ecs_pkg::DATA_BITS-1:0] d
	);
		return {ecs_pkg::STOP_BIT, d, ecs_pkg::START_BIT};
	endfunction : framed

	function automatic logic [ecs_pkg::PRBS_W-1:0] prbs_advance(
		input logic [ecs_pkg::PRBS_W-1:0] s
	);
		logic [ecs_pkg::PRBS_W-1:0] r;
		r = s;
		for (int i = 0; i < ecs_pkg::DATA_BITS; i++) begin
			r = {r[ecs_pkg::PRBS_W-2:0], r[ecs_pkg::PRBS_W-1] ^ r[ecs_pkg::PRBS_W-2]};
		end
		return r;
	endfunction : prbs_advance

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] in_meta_ff;
	logic [SYNC_W-1:0] in_sync_ff;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			in_meta_ff <= '0;
			in_sync_ff <= '0;
		end else begin
			in_meta_ff <= {parallel_word_clock_i, channel_data_in_i, channel_align_request_i,
				channel_sleep_n_i, output_drive_enable_i, global_sleep_n_i,
				selftest_activate_i, selftest_channel_select_i};
			in_sync_ff <= in_meta_ff;
		end
	end

	logic wclk_s;
	logic [ecs_pkg::WORD_BITS-1:0] data_s;
	logic [ecs_pkg::CHANNELS-1:0] align_req_s;
	logic [ecs_pkg::CHANNELS-1:0] chan_sleep_n_s;
	logic drive_en_s;
	logic global_sleep_n_s;
	logic st_act_s;
	logic [ecs_pkg::SEL_BITS-1:0] st_sel_s;

	assign {wclk_s, data_s, align_req_s, chan_sleep_n_s, drive_en_s, global_sleep_n_s,
		st_act_s, st_sel_s} = in_sync_ff;

	// ----------------------------------------------------------------
	// word clock edge and period
	// ----------------------------------------------------------------
	logic wclk_prev_ff;
	logic word_edge;
	logic [ecs_pkg::PERIOD_W-1:0] period_cnt_ff;
	logic [ecs_pkg::PERIOD_W-1:0] period_ff;

	assign word_edge = wclk_s && !wclk_prev_ff;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			wclk_prev_ff <= 1'b0;
		end else begin
			wclk_prev_ff <= wclk_s;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			period_cnt_ff <= '0;
			period_ff <= ecs_pkg::PERIOD_DEFAULT;
		end else if (word_edge) begin
			period_cnt_ff <= '0;
			period_ff <= period_cnt_ff + 1'b1;
		end else if (period_cnt_ff != ecs_pkg::PERIOD_MAX) begin
			period_cnt_ff <= period_cnt_ff + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// word capture into the buffer
	// ----------------------------------------------------------------
	logic [ecs_pkg::WORD_BITS-1:0] captured_ff;
	logic push_ff;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [ecs_pkg::WORD_BITS-1:0] fifo_out_data;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			captured_ff <= '0;
			push_ff <= 1'b0;
		end else begin
			push_ff <= word_edge;
			if (word_edge) begin
				captured_ff <= data_s;
			end
		end
	end

	ecs_word_fifo #(
		.WIDTH(ecs_pkg::WORD_BITS),
		.DEPTH(ecs_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i(mclk_i),
		.reset_i(reset_i),
		.in_valid_i(push_ff),
		.in_ready_o(fifo_in_ready),
		.in_data_i(captured_ff),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(word_edge),
		.out_data_o(fifo_out_data)
	);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			word_accept_o <= 1'b0;
		end else begin
			word_accept_o <= fifo_in_ready;
		end
	end

	// ----------------------------------------------------------------
	// initialization (PLL lock wait)
	// ----------------------------------------------------------------
	logic [9:0] lock_cnt_ff;

	always_ff @(posedge mclk_i) begin
		if (reset_i || !global_sleep_n_s) begin
			lock_cnt_ff <= '0;
			link_ready_o <= 1'b0;
		end else if (word_edge) begin
			if (lock_cnt_ff != ecs_pkg::PLL_LOCK) begin
				lock_cnt_ff <= lock_cnt_ff + 1'b1;
			end else begin
				link_ready_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// per-channel wake and alignment request
	// ----------------------------------------------------------------
	logic [ecs_pkg::CHANNELS-1:0][6:0] wake_cnt_ff;
	logic [ecs_pkg::CHANNELS-1:0][2:0] align_cnt_ff;
	logic [ecs_pkg::CHANNELS-1:0] align_active;

	always_ff @(posedge mclk_i) begin
		for (int c = 0; c < ecs_pkg::CHANNELS; c++) begin
			if (reset_i || !chan_sleep_n_s[c] || !link_ready_o || !global_sleep_n_s) begin
				wake_cnt_ff[c] <= '0;
				channel_ready_o[c] <= 1'b0;
			end else if (word_edge) begin
				if (wake_cnt_ff[c] != ecs_pkg::CHAN_WAKE) begin
					wake_cnt_ff[c] <= wake_cnt_ff[c] + 1'b1;
				end else begin
					channel_ready_o[c] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		for (int c = 0; c < ecs_pkg::CHANNELS; c++) begin
			if (reset_i || !align_req_s[c]) begin
				align_cnt_ff[c] <= '0;
			end else if (word_edge && align_cnt_ff[c] != ecs_pkg::ALIGN_HOLD) begin
				align_cnt_ff[c] <= align_cnt_ff[c] + 1'b1;
			end
		end
	end

	always_comb begin
		for (int c = 0; c < ecs_pkg::CHANNELS; c++) begin
			align_active[c] = (align_cnt_ff[c] == ecs_pkg::ALIGN_HOLD);
		end
	end

	// ----------------------------------------------------------------
	// self-test pattern source
	// ----------------------------------------------------------------
	logic [ecs_pkg::PRBS_W-1:0] prbs_ff;
	logic [ecs_pkg::CHANNELS-1:0] st_mask;

	assign st_mask = selftest_mask(st_act_s, st_sel_s);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			prbs_ff <= ecs_pkg::PRBS_SEED;
		end else if (word_edge) begin
			prbs_ff <= prbs_advance(prbs_ff);
		end
	end

	// ----------------------------------------------------------------
	// frame selection per channel
	// ----------------------------------------------------------------
	ecs_lane_if lane_bus ();
	logic [ecs_pkg::CHANNELS-1:0][ecs_pkg::FRAME_BITS-1:0] nxt_frames;

	// alignment beats self-test, self-test beats data
	always_comb begin
		for (int c = 0; c < ecs_pkg::CHANNELS; c++) begin
			if (align_active[c]) begin
				nxt_frames[c] = ecs_pkg::ALIGN_FRAME;
			end else if (st_mask[c]) begin
				nxt_frames[c] = framed(prbs_ff[ecs_pkg::DATA_BITS-1:0]);
			end else if (fifo_out_valid) begin
				nxt_frames[c] = framed(fifo_out_data[c*ecs_pkg::DATA_BITS +: ecs_pkg::DATA_BITS]);
			end else begin
				nxt_frames[c] = ecs_pkg::ALIGN_FRAME;
			end
		end
	end

	assign lane_bus.frames = nxt_frames;
	assign lane_bus.load = word_edge;

	// ----------------------------------------------------------------
	// bit rate: eleven evenly spread ticks per measured word period
	// ----------------------------------------------------------------
	logic [ecs_pkg::PERIOD_W:0] acc_ff;
	logic [3:0] bit_idx_ff;
	logic tick_ff;
	logic [ecs_pkg::PERIOD_W:0] nxt_acc;

	assign nxt_acc = acc_ff + {5'h00, ecs_pkg::BITS_PER_WORD};

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			acc_ff <= '0;
			bit_idx_ff <= '0;
			tick_ff <= 1'b0;
		end else if (word_edge) begin
			// half a period head start, so the stop bit goes out before the next load
			acc_ff <= {2'b00, period_ff[ecs_pkg::PERIOD_W-1:1]};
			bit_idx_ff <= '0;
			tick_ff <= 1'b0;
		end else if (bit_idx_ff == ecs_pkg::LAST_BIT_IDX) begin
			tick_ff <= 1'b0;
		end else if (nxt_acc >= {1'b0, period_ff}) begin
			acc_ff <= nxt_acc - {1'b0, period_ff};
			bit_idx_ff <= bit_idx_ff + 1'b1;
			tick_ff <= 1'b1;
		end else begin
			acc_ff <= nxt_acc;
			tick_ff <= 1'b0;
		end
	end

	assign lane_bus.tick = tick_ff;

	ecs_lane_shifter u_shift (
		.clk_i(mclk_i),
		.reset_i(reset_i),
		.lane(lane_bus.lane)
	);

	// ----------------------------------------------------------------
	// output pins
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			serial_out_pair_p_o <= '0;
			serial_out_pair_n_o <= '1;
			serial_out_pair_oe_n_o <= '1;
		end else begin
			serial_out_pair_p_o <= lane_bus.bits;
			serial_out_pair_n_o <= ~lane_bus.bits;
			for (int c = 0; c < ecs_pkg::CHANNELS; c++) begin
				// drive enable gates only the pins, state runs on
				serial_out_pair_oe_n_o[c] <= !(drive_en_s && global_sleep_n_s
					&& chan_sleep_n_s[c] && channel_ready_o[c]);
			end
		end
	end
endmodule : ecs_serializer_top
`default_nettype wire

// ---- src/ecs_word_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module ecs_word_fifo #(
	parameter int WIDTH = 80,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_ff;
	logic [AW:0] rd_ptr_ff;
	logic full;
	logic empty;
	logic do_wr;
	logic do_rd;

	assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	assign empty = (wr_ptr_ff == rd_ptr_ff);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr_ff[AW-1:0]];
	assign do_wr = in_valid_i && !full;
	assign do_rd = out_ready_i && !empty;

	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem[wr_ptr_ff[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
		end
	end
endmodule : ecs_word_fifo
`default_nettype wire
